// File: core/tdmg_pkg.sv
// constants for the tdm stream group configuration bank
// assumes byte addressing on a 32-bit apb bus, one word per group
package tdmg_pkg;

  localparam int unsigned NUM_GROUPS = 32;
  localparam int unsigned STREAMS_PER_GROUP = 4;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned ADDR_W = 20;

  localparam logic [19:0] GRP_BASE_ADDR = 20'h40200;
  localparam logic [19:0] GRP_LAST_ADDR = 20'h4027F;
  localparam logic [31:0] GRP_RESET = 32'h000C000C;
  localparam logic [31:0] GRP_WR_MASK = 32'h007F03FF;

  localparam int unsigned IN_SRC_LSB = 0;
  localparam int unsigned IN_RATE_LSB = 2;
  localparam int unsigned IN_DELAY_LSB = 4;
  localparam int unsigned IN_DELAY_W = 5;
  localparam int unsigned IN_INV_BIT = 9;
  localparam int unsigned OUT_SRC_LSB = 16;
  localparam int unsigned OUT_RATE_LSB = 18;
  localparam int unsigned OUT_ADV_LSB = 20;
  localparam int unsigned OUT_INV_BIT = 22;

  // basic switching rate; every group rate is this divided by 1, 2, 4 or 8
  localparam int unsigned BASE_RATE_KBPS = 65536;
  localparam logic [1:0] RATE_CODE_TOP = 2'h3;
  localparam logic [3:0] RATE_DIV_SLOWEST = 4'h8;

  // advancement in tenths of a nanosecond
  localparam logic [7:0] ADV_LOW_1 = 8'h4C;
  localparam logic [7:0] ADV_LOW_2 = 8'h98;
  localparam logic [7:0] ADV_TOP_1 = 8'h26;
  localparam logic [7:0] ADV_TOP_2 = ADV_LOW_1;
  localparam logic [1:0] ADV_CODE_1 = 2'h1;
  localparam logic [1:0] ADV_CODE_2 = 2'h2;

endpackage : tdmg_pkg

// File: core/tdmg_regbus_if.sv
// carrier between the apb front end and the group register array
// assumes both ends share one clock
`timescale 1ns/10ps
interface tdmg_regbus_if;
  logic wr_en;
  logic rd_en;
  logic [tdmg_pkg::IDX_W-1:0] idx;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic [31:0] rdata;

  modport port (
    output wr_en,
    output rd_en,
    output idx,
    output wdata,
    output wstrb,
    input rdata
  );

  modport regs (
    input wr_en,
    input rd_en,
    input idx,
    input wdata,
    input wstrb,
    output rdata
  );
endinterface : tdmg_regbus_if

// File: core/tdmg_apb_port.sv
// apb slave front end: address decode, strobes, registered answer
// assumes a well behaved apb master on the same clock
`timescale 1ns/10ps
module tdmg_apb_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [tdmg_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  tdmg_regbus_if.port bus
);

  logic hit;
  logic setup;
  logic access;
  logic [19:0] offset;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // one long word per group from the base up, aligned only
  always_comb begin
    offset = paddr_i - tdmg_pkg::GRP_BASE_ADDR;
    hit = (paddr_i >= tdmg_pkg::GRP_BASE_ADDR) &&
          (paddr_i <= tdmg_pkg::GRP_LAST_ADDR) &&
          (paddr_i[1:0] == 2'h0);
  end

  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;

  assign bus.idx = offset[6:2];
  assign bus.wdata = pwdata_i;
  assign bus.wstrb = pstrb_i;
  assign bus.wr_en = access && pwrite_i && hit;
  assign bus.rd_en = setup && !pwrite_i && hit;

  // answer is captured in setup so the access phase needs no wait
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= bus.rd_en ? bus.rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !hit;
    end
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_q && access;

  a_unmapped_error: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (setup && !hit) |=> (penable_i |-> pslverr_o && prdata_o == 32'h0))
    else $error("unmapped access not flagged");

endmodule // tdmg_apb_port

// File: core/tdmg_group_regs.sv
// stream group configuration bank with per-stream field fan-out
// assumes an apb master on CLK_I; streams sit in groups of four
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps

// Overview of operation
// - streams grouped four in, four out
// - group's four inputs share input settings
// - group's four outputs share output settings
// - thirty-two registers, one per group
// - group n at base plus four n
// - rates derived from one basic switching rate
module tdmg_group_regs #(
  parameter int unsigned NUM_GROUPS = tdmg_pkg::NUM_GROUPS,
  parameter int unsigned STREAMS_PER_GROUP = tdmg_pkg::STREAMS_PER_GROUP
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [tdmg_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0][1:0] IN_SRC_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0][1:0] IN_RATE_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0][4:0] IN_DELAY_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0] IN_INV_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0][1:0] OUT_SRC_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0][1:0] OUT_RATE_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0][1:0] OUT_ADV_O,
  output logic [NUM_GROUPS*STREAMS_PER_GROUP-1:0] OUT_INV_O,
  output logic [NUM_GROUPS-1:0][3:0] IN_RATE_DIV_O,
  output logic [NUM_GROUPS-1:0][3:0] OUT_RATE_DIV_O,
  output logic [NUM_GROUPS-1:0][7:0] OUT_ADV_TENTH_NS_O
);

  localparam int unsigned NUM_STREAMS = NUM_GROUPS * STREAMS_PER_GROUP;

  logic [31:0] cfg_q [NUM_GROUPS];
  logic [tdmg_pkg::IDX_W-1:0] nb_idx;
  logic [31:0] nb_val;
  logic seen_q;

  tdmg_regbus_if bus ();

  tdmg_apb_port tdmg_apb_port_i (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .psel_i(PSEL_I),
    .penable_i(PENABLE_I),
    .pwrite_i(PWRITE_I),
    .paddr_i(PADDR_I),
    .pwdata_i(PWDATA_I),
    .pstrb_i(PSTRB_I),
    .prdata_o(PRDATA_O),
    .pready_o(PREADY_O),
    .pslverr_o(PSLVERR_O),
    .bus(bus.port)
  );

  // byte lane merge, then drop reserved bits so they always read zero
  function automatic logic [31:0] merge_word(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res & tdmg_pkg::GRP_WR_MASK;
  endfunction

  // stream rate as a divisor of the basic switching rate
  function automatic logic [3:0] rate_div(input logic [1:0] code);
    return tdmg_pkg::RATE_DIV_SLOWEST >> code;
  endfunction

  // advancement halves at the top rate; code 3 is treated as none
  function automatic logic [7:0] adv_tenths(
    input logic [1:0] adv,
    input logic [1:0] rate
  );
    logic top;
    logic [7:0] res;
    top = (rate == tdmg_pkg::RATE_CODE_TOP);
    res = 8'h00;
    if (adv == tdmg_pkg::ADV_CODE_1) begin
      res = top ? tdmg_pkg::ADV_TOP_1 : tdmg_pkg::ADV_LOW_1;
    end else if (adv == tdmg_pkg::ADV_CODE_2) begin
      res = top ? tdmg_pkg::ADV_TOP_2 : tdmg_pkg::ADV_LOW_2;
    end
    return res;
  endfunction

  // a write only ever lands in the one addressed group word
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        cfg_q[g] <= tdmg_pkg::GRP_RESET;
      end
    end else if (bus.wr_en) begin
      cfg_q[bus.idx] <= merge_word(cfg_q[bus.idx], bus.wdata,
                                   bus.wstrb);
    end
  end

  assign bus.rdata = cfg_q[bus.idx];

  // one group word drives every stream of that group alike
  for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_stream
    localparam int unsigned G = s / STREAMS_PER_GROUP;
    assign IN_SRC_O[s] = cfg_q[G][tdmg_pkg::IN_SRC_LSB +: 2];
    assign IN_RATE_O[s] = cfg_q[G][tdmg_pkg::IN_RATE_LSB +: 2];
    assign IN_DELAY_O[s] =
      cfg_q[G][tdmg_pkg::IN_DELAY_LSB +: tdmg_pkg::IN_DELAY_W];
    assign IN_INV_O[s] = cfg_q[G][tdmg_pkg::IN_INV_BIT];
    assign OUT_SRC_O[s] = cfg_q[G][tdmg_pkg::OUT_SRC_LSB +: 2];
    assign OUT_RATE_O[s] = cfg_q[G][tdmg_pkg::OUT_RATE_LSB +: 2];
    assign OUT_ADV_O[s] = cfg_q[G][tdmg_pkg::OUT_ADV_LSB +: 2];
    assign OUT_INV_O[s] = cfg_q[G][tdmg_pkg::OUT_INV_BIT];

    a_in_fanout: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      IN_RATE_O[s] == IN_RATE_O[G*STREAMS_PER_GROUP] &&
      IN_DELAY_O[s] == IN_DELAY_O[G*STREAMS_PER_GROUP])
      else $error("input streams of a group differ");

    a_out_fanout: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      OUT_RATE_O[s] == OUT_RATE_O[G*STREAMS_PER_GROUP] &&
      OUT_INV_O[s] == OUT_INV_O[G*STREAMS_PER_GROUP])
      else $error("output streams of a group differ");
  end

  // per-group rate and advancement decodes for the timing logic
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
    assign IN_RATE_DIV_O[g] =
      rate_div(cfg_q[g][tdmg_pkg::IN_RATE_LSB +: 2]);
    assign OUT_RATE_DIV_O[g] =
      rate_div(cfg_q[g][tdmg_pkg::OUT_RATE_LSB +: 2]);
    assign OUT_ADV_TENTH_NS_O[g] =
      adv_tenths(cfg_q[g][tdmg_pkg::OUT_ADV_LSB +: 2],
                 cfg_q[g][tdmg_pkg::OUT_RATE_LSB +: 2]);
  end

  // helper logic watched only by the checks below
  assign nb_idx = bus.idx + 5'h01;
  assign nb_val = cfg_q[nb_idx];

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_reset_value: assert property (
    !seen_q |-> cfg_q[0] == tdmg_pkg::GRP_RESET &&
                cfg_q[NUM_GROUPS-1] == tdmg_pkg::GRP_RESET)
    else $error("group word not at reset value");

  a_write_lands: assert property (
    (bus.wr_en && bus.wstrb == 4'hF) |=>
      cfg_q[$past(bus.idx)] == ($past(bus.wdata) & tdmg_pkg::GRP_WR_MASK))
    else $error("full write not stored");

  a_no_cross_write: assert property (
    bus.wr_en |=> cfg_q[$past(nb_idx)] == $past(nb_val))
    else $error("write disturbed another group");

  a_read_back: assert property (
    (bus.rd_en && !PWRITE_I) |=>
      PRDATA_O == $past(bus.rdata) &&
      (PRDATA_O & ~tdmg_pkg::GRP_WR_MASK) == 32'h0)
    else $error("read data wrong or reserved bits set");

  a_group_map: assert property (
    (PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I == 4'hF &&
     PADDR_I == tdmg_pkg::GRP_BASE_ADDR + 20'h0000C) |=>
      cfg_q[3] == ($past(PWDATA_I) & tdmg_pkg::GRP_WR_MASK))
    else $error("group three not at base plus twelve");

  a_rate_base: assert property (
    OUT_RATE_O[0] == tdmg_pkg::RATE_CODE_TOP |-> OUT_RATE_DIV_O[0] == 4'h1 ##0
    (OUT_RATE_O[0] == 2'h0 || OUT_RATE_DIV_O[0] != 4'h8))
    else $error("top rate divisor wrong");

  a_rate_slow: assert property (
    IN_RATE_O[0] == 2'h0 |-> IN_RATE_DIV_O[0] == 4'h8)
    else $error("slowest rate divisor wrong");

  a_adv_top: assert property (
    (OUT_ADV_O[0] == 2'h1 && OUT_RATE_O[0] == 2'h3) |->
      OUT_ADV_TENTH_NS_O[0] == 8'h26)
    else $error("top rate advancement wrong");

  a_adv_low: assert property (
    (OUT_ADV_O[0] == 2'h2 && OUT_RATE_O[0] != 2'h3) |->
      OUT_ADV_TENTH_NS_O[0] == 8'h98)
    else $error("lower rate advancement wrong");

  c_write: cover property (bus.wr_en ##1 bus.rd_en);
  c_read: cover property (bus.rd_en ##1 PENABLE_I);
  c_unmapped: cover property (PSLVERR_O);
  c_top_rate: cover property (OUT_RATE_DIV_O[0] == 4'h1);

endmodule // tdmg_group_regs

// File: tb/tdmg_apb_host.sv
// apb master model standing in for the host processor
// assumes a slave on the same clock; one transfer at a time
`timescale 1ns/10ps
module tdmg_apb_host (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic [31:0] prdata_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [19:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 20'h00000;
    pwdata_o = 32'h00000000;
    pstrb_o = 4'h0;
  end

  // one setup and access; request held until pready seen high or 16 cycles pass
  task automatic xfer(input logic w, input logic [19:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q, output logic e,
                      output bit ok);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= w ? d : ~pwdata_o;
    pstrb_o <= w ? s : 4'h0;
    @(posedge clk_i);
    penable_o <= 1'b1;
    ok = 1'b0;
    n = 0;
    while (!ok && n < 16) begin
      @(posedge clk_i);
      n++;
      ok = (pready_i === 1'b1);
    end
    q = prdata_i;
    e = pslverr_i;
    // released lines change so stale values cannot pass for valid ones
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~pwdata_o;
  endtask
endmodule // tdmg_apb_host

// File: tb/tdmg_group_regs_tb.sv
// self-checking bench for the stream group configuration bank
// assumes the apb host model drives every bus input
`timescale 1ns/10ps
module tdmg_group_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [127:0][1:0] isrc, irate, osrc, orate, oadv;
  logic [127:0][4:0] idel;
  logic [127:0] iinv, oinv;
  logic [31:0][3:0] idiv, odiv;
  logic [31:0][7:0] adv_t;
  int failures = 0;
  int comparisons = 0;

  always #20 clk = ~clk;

  tdmg_apb_host tdmg_apb_host_i (.clk_i(clk), .pready_i(pready),
    .prdata_i(prdata), .pslverr_i(pslverr), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .pstrb_o(pstrb));

  tdmg_group_regs tdmg_group_regs_i (.CLK_I(clk), .RST_N_I(rst_n),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IN_SRC_O(isrc), .IN_RATE_O(irate), .IN_DELAY_O(idel),
    .IN_INV_O(iinv), .OUT_SRC_O(osrc), .OUT_RATE_O(orate),
    .OUT_ADV_O(oadv), .OUT_INV_O(oinv), .IN_RATE_DIV_O(idiv),
    .OUT_RATE_DIV_O(odiv), .OUT_ADV_TENTH_NS_O(adv_t));

  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] x, logic [31:0] y);
    comparisons++;
    if (y !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, x, y);
    end
  endtask

  task automatic acc(logic w, logic [19:0] a, logic [31:0] d,
                     logic [3:0] s, logic [31:0] xq, logic xe);
    logic [31:0] q;
    logic e;
    bit ok;
    tdmg_apb_host_i.xfer(w, a, d, s, q, e, ok);
    if (!ok) begin
      failures++;
      $display("mismatch pready expected 1 seen 0");
      end_of_test();
    end else begin
      if (!w) chk("prdata", xq, q);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
    end
  endtask

  // distinct word per group; reserved bits written as zero
  function automatic logic [31:0] gv(int g);
    logic [4:0] b;
    b = g[4:0];
    return {9'h0, b[4], b[1:0], b[3:2], ~b[1:0], 6'h0, b[0], b,
            ~b[3:2], b[1:0]};
  endfunction

  function automatic logic [7:0] adv(logic [1:0] c, logic [1:0] r);
    case (c)
      2'h1: return (r == 2'h3) ? 8'h26 : 8'h4C;
      2'h2: return (r == 2'h3) ? 8'h4C : 8'h98;
      default: return 8'h00;
    endcase
  endfunction

  // read group g and compare word and its four streams each way
  task automatic grp(int g, logic [31:0] v);
    acc(1'b0, 20'h40200 + 20'(4 * g), 32'h0, 4'h0, v,
        1'b0);
    for (int s = 4 * g; s < 4 * g + 4; s++) begin
      chk("in", {22'h0, v[9:0]}, {22'h0, iinv[s], idel[s], irate[s],
          isrc[s]});
      chk("out", {25'h0, v[22:16]}, {25'h0, oinv[s], oadv[s], orate[s],
          osrc[s]});
    end
    chk("idiv", {28'h0, 4'h8 >> v[3:2]}, {28'h0, idiv[g]});
    chk("odiv", {28'h0, 4'h8 >> v[19:18]}, {28'h0, odiv[g]});
    chk("adv", {24'h0, adv(v[21:20], v[19:18])}, {24'h0, adv_t[g]});
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int g = 0; g < 32; g++) grp(g, tdmg_pkg::GRP_RESET);
    $display("test reset values done");
    for (int g = 0; g < 32; g++)
      acc(1'b1, 20'h40200 + 20'(4 * g), gv(g), 4'hF, 0, 1'b0);
    for (int g = 0; g < 32; g++) grp(g, gv(g));
    $display("test group map done");
    acc(1'b1, 20'h40280, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1);
    acc(1'b1, 20'h401FC, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1);
    acc(1'b1, 20'h40202, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1);
    acc(1'b0, 20'h40280, 32'h0, 4'h0, 32'h0, 1'b1);
    grp(0, gv(0));
    grp(31, gv(31));
    acc(1'b1, 20'h40214, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b0);
    grp(5, 32'h007F03FF);
    acc(1'b1, 20'h40218, 32'h0, 4'h4, 32'h0, 1'b0);
    grp(6, gv(6) & 32'hFF00FFFF);
    $display("test refusals done");
    // group 0 words that reach the slowest rate and both advance codes
    acc(1'b1, 20'h40200, 32'h001C0000, 4'hF, 32'h0, 1'b0);
    grp(0, 32'h001C0000);
    acc(1'b1, 20'h40200, 32'h00240004, 4'hF, 32'h0, 1'b0);
    grp(0, 32'h00240004);
    $display("test rate and advance done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    grp(0, tdmg_pkg::GRP_RESET);
    grp(5, tdmg_pkg::GRP_RESET);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule // tdmg_group_regs_tb
